/* design/lrsa_map.vh */
// constants for the loop response sine analyzer
`ifndef LRSA_MAP_VH
`define LRSA_MAP_VH
`define LRSA_TBL_ABITS 6
`define LRSA_TBL_LEN 64
`define LRSA_FRAC_BITS 10
`define LRSA_SMP_W 16
`define LRSA_AMP_W 16
`define LRSA_CNT_W 24
`define LRSA_ACC_W 48
`define LRSA_ST_IDLE 2'h0
`define LRSA_ST_RUN 2'h1
`define LRSA_ST_DONE 2'h2
`endif

/* design/lrsa_sine_rom.v */
// quarter-shifted sine and cosine lookup from one fixed period table
`timescale 1ns/1ps
`include "lrsa_map.vh"
module lrsa_sine_rom #(
  parameter ABITS = `LRSA_TBL_ABITS
) (
  // clock and reset
  input wire mclk,
  input wire rstn,
  // table addresses
  input wire [ABITS-1:0] sinAddr,
  input wire [ABITS-1:0] cosAddr,
  // looked-up samples
  output reg signed [15:0] sinVal,
  output reg signed [15:0] cosVal
);

  // ************************************************
  // fixed table, one period of a sine, 64 entries
  // ************************************************
  function signed [15:0] tblRead;
    input [5:0] a;
    reg [4:0] q;
    reg [15:0] m;
    begin
      // second quarter mirrors about entry 16, the crest
      q = (a[4] == 1'b0) ? {1'b0, a[3:0]} : (5'h10 - {1'b0, a[3:0]});
      case (q)
        5'h00: m = 16'h0000;
        5'h01: m = 16'h0c8c;
        5'h02: m = 16'h18f9;
        5'h03: m = 16'h2528;
        5'h04: m = 16'h30fb;
        5'h05: m = 16'h3c56;
        5'h06: m = 16'h471c;
        5'h07: m = 16'h5133;
        5'h08: m = 16'h5a82;
        5'h09: m = 16'h62f1;
        5'h0a: m = 16'h6a6d;
        5'h0b: m = 16'h70e2;
        5'h0c: m = 16'h7641;
        5'h0d: m = 16'h7a7c;
        5'h0e: m = 16'h7d89;
        5'h0f: m = 16'h7f61;
        default: m = 16'h7fff;
      endcase
      tblRead = a[5] ? (16'h0000 - m) : m;
    end
  endfunction

  // registered lookups
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sinVal <= 16'h0000;
      cosVal <= 16'h0000;
    end else begin
      sinVal <= tblRead(sinAddr[5:0]);
      cosVal <= tblRead(cosAddr[5:0]);
    end
  end
endmodule

/* design/lrsa_top.v */
// loop response sine analyzer: excitation generator and correlator
// Overview of operation
// - excitation is added to compensator output while measuring.
// - response samples come from the error ADC output.
// - samples come from a fixed one-period sine table.
// - each sample, index grows by frequency step, then table lookup.
// - index passing table end wraps by subtracting table length.
// - index keeps fraction; address is index truncated.
// - step equals table length times frequency over sample rate.
// - cosine read at sine index plus quarter table, same wrap.
// - power-of-two table wraps by dropping upper index bits.
// - response times sine and cosine summed into imaginary and real.
// - result is just two words, real and imaginary sums.
// - no window; sample count is cycles times rate ratio, rounded.
// - PID description leaves the compensator datapath unchanged.
`timescale 1ns/1ps
`include "lrsa_map.vh"
module lrsa_top #(
  parameter ABITS = `LRSA_TBL_ABITS,
  parameter FBITS = `LRSA_FRAC_BITS,
  parameter SW = `LRSA_SMP_W,
  parameter CW = `LRSA_CNT_W,
  parameter AW = `LRSA_ACC_W
) (
  // clock and reset
  input wire mclk,
  input wire rstn,
  // loop sample strobe
  input wire sampleStb,
  // host control
  input wire startCmd,
  input wire [ABITS+FBITS-1:0] freqStep,
  input wire [CW-1:0] sampleCount,
  input wire [15:0] exciteAmp,
  // loop datapath
  input wire signed [SW-1:0] compOut,
  input wire signed [SW-1:0] errAdc,
  output reg signed [SW-1:0] loopDrive,
  // results
  output reg signed [AW-1:0] realSum,
  output reg signed [AW-1:0] imagSum,
  output reg measBusy,
  output reg measDone
);

  localparam IW = ABITS + FBITS;
  localparam [1:0] ST_IDLE = `LRSA_ST_IDLE;
  localparam [1:0] ST_RUN = `LRSA_ST_RUN;
  localparam [1:0] ST_DONE = `LRSA_ST_DONE;
  localparam integer QTR_LEN = `LRSA_TBL_LEN / 4;
  localparam [ABITS-1:0] QUARTER = QTR_LEN[ABITS-1:0];

  // ************************************************
  // state and phase
  // ************************************************
  reg [1:0] state;
  reg [IW-1:0] phase;
  reg [CW-1:0] count;
  reg lookStb;
  reg corrStb;
  reg signed [SW-1:0] errHold;
  reg signed [SW-1:0] errCorr;
  wire [ABITS-1:0] sinAddr;
  wire [ABITS-1:0] cosAddr;
  wire signed [15:0] sinVal;
  wire signed [15:0] cosVal;
  wire [IW-1:0] next_phase;

  // wrap by dropping carry, equal to subtracting table length
  assign next_phase = phase + freqStep;
  // truncated integer address from the full index
  assign sinAddr = phase[IW-1:FBITS];
  assign cosAddr = phase[IW-1:FBITS] + QUARTER;

  lrsa_sine_rom #(
    .ABITS(ABITS)
  ) uRom (
    .mclk(mclk),
    .rstn(rstn),
    .sinAddr(sinAddr),
    .cosAddr(cosAddr),
    .sinVal(sinVal),
    .cosVal(cosVal)
  );

  // measurement sequencer
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      phase <= {IW{1'b0}};
      count <= {CW{1'b0}};
      lookStb <= 1'b0;
      measBusy <= 1'b0;
      measDone <= 1'b0;
      errHold <= {SW{1'b0}};
    end else begin
      lookStb <= 1'b0;
      case (state)
        ST_IDLE, ST_DONE: begin
          if (startCmd) begin
            state <= ST_RUN;
            phase <= {IW{1'b0}};
            count <= {CW{1'b0}};
            measBusy <= 1'b1;
            measDone <= 1'b0;
          end
        end
        ST_RUN: begin
          if (sampleStb) begin
            errHold <= errAdc;
            lookStb <= 1'b1;
            phase <= next_phase;
            if (count + 1'b1 >= sampleCount) begin
              state <= ST_DONE;
              measBusy <= 1'b0;
              measDone <= 1'b1;
            end
            count <= count + 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************
  // excitation injection
  // ************************************************
  reg signed [SW+16:0] scaled;
  reg signed [SW+1:0] sumDrive;
  always @* begin
    scaled = $signed(sinVal) * $signed({1'b0, exciteAmp});
    sumDrive = $signed({{2{compOut[SW-1]}}, compOut}) +
      $signed(scaled[SW+16:16]);
  end

  // add excitation at compensator output, saturated
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      loopDrive <= {SW{1'b0}};
    end else if (!measBusy) begin
      loopDrive <= compOut;
    end else if (sumDrive > $signed({3'b000, {(SW-1){1'b1}}})) begin
      loopDrive <= {1'b0, {(SW-1){1'b1}}};
    end else if (sumDrive < $signed({3'b111, {(SW-1){1'b0}}})) begin
      loopDrive <= {1'b1, {(SW-1){1'b0}}};
    end else begin
      loopDrive <= sumDrive[SW-1:0];
    end
  end

  // ************************************************
  // correlator
  // ************************************************
  wire signed [SW+15:0] prodRe;
  wire signed [SW+15:0] prodIm;
  assign prodRe = errCorr * cosVal;
  assign prodIm = errCorr * sinVal;

  // accumulate after the table lookup settles
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      corrStb <= 1'b0;
      errCorr <= {SW{1'b0}};
      realSum <= {AW{1'b0}};
      imagSum <= {AW{1'b0}};
    end else begin
      corrStb <= lookStb;
      if (lookStb) begin
        errCorr <= errHold;
      end
      if (startCmd && !measBusy) begin
        realSum <= {AW{1'b0}};
        imagSum <= {AW{1'b0}};
      end else if (corrStb) begin
        realSum <= realSum + {{(AW-SW-16){prodRe[SW+15]}}, prodRe};
        imagSum <= imagSum + {{(AW-SW-16){prodIm[SW+15]}}, prodIm};
      end
    end
  end
endmodule

/* verif/lrsa_top_sva.sv */
// port checker for the loop response sine analyzer
`timescale 1ns/1ps
module lrsa_top_sva #(parameter ABITS = 6, FBITS = 10, SW = 16, CW = 24, AW = 48) (
  // clock and reset
  input wire mclk,
  input wire rstn,
  // inputs
  input wire sampleStb,
  input wire startCmd,
  input wire [ABITS+FBITS-1:0] freqStep,
  input wire [CW-1:0] sampleCount,
  input wire [15:0] exciteAmp,
  input wire signed [SW-1:0] compOut,
  input wire signed [SW-1:0] errAdc,
  // outputs
  input wire signed [SW-1:0] loopDrive,
  input wire signed [AW-1:0] realSum,
  input wire signed [AW-1:0] imagSum,
  input wire measBusy,
  input wire measDone
);
  reg [CW-1:0] nSmp;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // samples taken in the current run
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) nSmp <= {CW{1'b0}};
    else if (startCmd && !measBusy) nSmp <= {CW{1'b0}};
    else if (sampleStb && measBusy) nSmp <= nSmp + 1'b1;
  end
  sequence s_idle3;
    !measBusy [*3];
  endsequence
  sequence s_done4;
    measDone [*4];
  endsequence
  chk_start_busy: assert property (startCmd && !measBusy |=> measBusy)
    else $error("start not taken");
  chk_start_clear: assert property (startCmd && !measBusy |=> !realSum && !imagSum)
    else $error("sums not cleared");
  chk_idle_drive: assert property (s_idle3 |-> loopDrive == $past(compOut))
    else $error("excitation while idle");
  chk_done_holds: assert property (measDone && !startCmd |=> measDone)
    else $error("done dropped");
  chk_busy_ends: assert property ($fell(measBusy) |-> measDone)
    else $error("busy ended without done");
  chk_sums_hold: assert property (s_done4 ##0 !startCmd |=> $stable(realSum) && $stable(imagSum))
    else $error("result moved");
  chk_done_count: assert property ($rose(measDone) |-> nSmp == (sampleCount ? sampleCount : 1))
    else $error("wrong sample count");
  chk_no_early: assert property (measBusy |-> !measDone)
    else $error("done while busy");
endmodule
bind lrsa_top lrsa_top_sva #(.ABITS(ABITS), .FBITS(FBITS), .SW(SW), .CW(CW), .AW(AW)) i_chk (.*);

/* verif/lrsa_loop_model.sv */
// behavioural compensator and error converter of the loop
`timescale 1ns/1ps
module lrsa_loop_model (
  // clock and setting
  input wire mclk,
  input wire signed [15:0] level,
  // toward the analyzer
  output reg sampleStb = 1'b0,
  output reg signed [15:0] compOut = 16'h0000,
  output reg signed [15:0] errAdc = 16'h0000
);
  reg [1:0] ph = 2'h0;
  // strobe every fourth cycle, steady words
  always @(negedge mclk) begin
    ph <= ph + 2'h1;
    sampleStb <= (ph == 2'h0);
    compOut <= level;
    errAdc <= level >>> 2;
  end
endmodule

/* verif/lrsa_top_tb.sv */
// self-checking bench for the loop response sine analyzer
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
module lrsa_top_tb;
  reg mclk = 1'b0;
  reg rstn = 1'b0;
  reg startCmd = 1'b0;
  reg [15:0] freqStep = 16'h0000;
  reg [23:0] sampleCount = 24'h000001;
  reg [15:0] exciteAmp = 16'h0000;
  wire sampleStb, measBusy, measDone;
  wire signed [15:0] compOut, errAdc, loopDrive;
  wire signed [47:0] realSum, imagSum;
  int n_mismatch = 0;
  int tests_run = 0;
  localparam logic signed [15:0] LVL = 16'h0100;
  localparam int NPTS = 50;
  always #4 mclk = ~mclk;
  lrsa_top i_lrsa_top (.mclk(mclk), .rstn(rstn), .sampleStb(sampleStb), .startCmd(startCmd),
    .freqStep(freqStep), .sampleCount(sampleCount), .exciteAmp(exciteAmp), .compOut(compOut),
    .errAdc(errAdc), .loopDrive(loopDrive), .realSum(realSum), .imagSum(imagSum),
    .measBusy(measBusy), .measDone(measDone));
  lrsa_loop_model i_lrsa_loop_model (.mclk(mclk), .level(LVL), .sampleStb(sampleStb),
    .compOut(compOut), .errAdc(errAdc));
  task wrap_up;
    $display("mismatches %0d of %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // idle: plain compensator word, no done
  task t_idle;
    repeat (4) @(negedge mclk);
    `CHK(loopDrive, LVL)
    `CHK(measDone, 1'b0)
  endtask
  // whole cycles against a steady error word sum to zero
  task t_meas(input [15:0] st, input int cyc, input [15:0] amp);
    int k;
    bit moved;
    begin
      freqStep = st;
      sampleCount = cyc * 65536 / st;
      exciteAmp = amp;
      moved = 0;
      @(negedge mclk) startCmd = 1'b1;
      @(negedge mclk) startCmd = 1'b0;
      `CHK(measBusy, 1'b1)
      for (k = 0; k < 4000 && !measDone; k++) begin
        @(negedge mclk);
        startCmd = (k == 6);
        if (loopDrive !== LVL) moved = 1;
      end
      `CHK(measDone, 1'b1)
      repeat (4) @(negedge mclk);
      `CHK(realSum, 48'sh0)
      `CHK(imagSum, 48'sh0)
      `CHK(moved, amp != 16'h0000)
    end
  endtask
  // single sample: step 0 hits cosine crest, quarter step hits sine crest
  task t_one(input [15:0] st, input bit imPos);
    int k;
    begin
      freqStep = st;
      sampleCount = 24'h000001;
      exciteAmp = 16'h0000;
      @(negedge mclk) startCmd = 1'b1;
      @(negedge mclk) startCmd = 1'b0;
      for (k = 0; k < 40 && !measDone; k++) @(negedge mclk);
      `CHK(measDone, 1'b1)
      repeat (4) @(negedge mclk);
      `CHK(realSum > 48'sh0, !imPos)
      `CHK(imagSum > 48'sh0, imPos)
      `CHK((imPos ? realSum : imagSum), 48'sh0)
    end
  endtask
  // host sweep: one point per frequency, j whole cycles at point j, amplitude trimmed
  task t_sweep;
    reg [15:0] stp;
    reg [15:0] amp;
    int j;
    begin
      stp = 16'h0000;
      amp = 16'hffff;
      for (j = 1; j <= NPTS; j++) begin
        stp = stp + 16'h0200;
        amp = amp - 16'h0100;
        t_meas(stp, j, amp);
      end
    end
  endtask
  // main sequence
  initial begin
    repeat (10) @(negedge mclk);
    rstn = 1'b1;
    t_idle;
    t_one(16'h0000, 1'b0);
    t_one(16'h4000, 1'b1);
    t_meas(16'h4000, 2, 16'hffff);
    t_meas(16'h5000, 5, 16'h8000);
    t_meas(16'h0800, 1, 16'h4000);
    t_meas(16'h0200, 1, 16'hffff);
    t_meas(16'h2000, 2, 16'h0000);
    t_sweep;
    wrap_up;
  end
  // watchdog, about twice the sweep and the single points
  initial begin
    #400000;
    n_mismatch++;
    wrap_up;
  end
endmodule
